/* File: rtl/oscsd_pkg.sv */
// Purpose: Shared constants and types for the oscillator select and slowdown block
// Assumes: 16-bit register data, word-aligned byte offsets, 25 MHz system clock
// Notes: Offsets and interrupt bit positions are fixed here and used by all files except the divider
package oscsd_pkg;

  // Register bus geometry
  localparam int unsigned OSCSD_AW = 8;
  localparam int unsigned OSCSD_DW = 16;

  // Register byte offsets
  localparam logic [7:0] OSCSD_OFF_OSC_CONTROL = 8'h00;
  localparam logic [7:0] OSCSD_OFF_CLOCK_DIVIDE = 8'h04;
  localparam logic [7:0] OSCSD_OFF_FAST_RC_TRIM = 8'h08;
  localparam logic [7:0] OSCSD_OFF_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] OSCSD_OFF_IRQ_ENABLE = 8'h10;
  localparam logic [7:0] OSCSD_OFF_IRQ_CLEAR = 8'h14;

  // Clock source encodings
  localparam logic [2:0] OSCSD_SRC_FAST_RC = 3'h0;
  localparam logic [2:0] OSCSD_SRC_FAST_RC_PLL = 3'h1;
  localparam logic [2:0] OSCSD_SRC_PRIMARY = 3'h2;
  localparam logic [2:0] OSCSD_SRC_PRIMARY_PLL = 3'h3;
  localparam logic [2:0] OSCSD_SRC_SECONDARY = 3'h4;
  localparam logic [2:0] OSCSD_SRC_LOW_POWER_RC = 3'h5;
  localparam logic [2:0] OSCSD_SRC_LP_FAST_RC_DIV = 3'h6;
  localparam logic [2:0] OSCSD_SRC_FAST_RC_DIV = 3'h7;

  // Reset values
  localparam logic [2:0] OSCSD_RST_SLOWDOWN_RATIO = 3'h3;
  localparam logic [2:0] OSCSD_RST_POSTSCALE = 3'h1;

  // Interrupt status bit positions
  localparam int unsigned OSCSD_IRQ_N = 3;
  localparam int unsigned OSCSD_IRQ_SWITCH_DONE = 0;
  localparam int unsigned OSCSD_IRQ_CLK_FAIL = 1;
  localparam int unsigned OSCSD_IRQ_PLL_LOCK = 2;

  // Switch settle time in ns and its cycle count at 25 MHz (longest time, rounds down)
  localparam int unsigned OSCSD_CLK_PERIOD_NS = 40;
  localparam int unsigned OSCSD_SWITCH_TIME_NS = 1000;
  localparam int unsigned OSCSD_SWITCH_CYCLES =
    (OSCSD_SWITCH_TIME_NS / OSCSD_CLK_PERIOD_NS) < 1 ? 1 :
    (OSCSD_SWITCH_TIME_NS / OSCSD_CLK_PERIOD_NS);

  // Switch sequencer states, one-hot
  typedef enum logic [2:0] {
    OSCSD_SW_IDLE = 3'b001,
    OSCSD_SW_WAIT = 3'b010,
    OSCSD_SW_DONE = 3'b100
  } oscsd_sw_state_t;

  // Oscillator control fields
  typedef struct packed {
    logic [2:0] active_source_sel;
    logic [2:0] requested_source_sel;
    logic switch_lockout;
    logic pll_lock;
    logic clk_fail_flag;
    logic secondary_drive_strength;
    logic secondary_osc_on;
    logic switch_request;
  } oscsd_osc_ctl_t;

  // Clock divide fields
  typedef struct packed {
    logic recover_on_irq;
    logic [2:0] slowdown_ratio;
    logic slowdown_enable;
    logic [2:0] fast_rc_postscale;
  } oscsd_clk_div_t;

endpackage

/* File: rtl/oscsd_pow2_div.sv */
// Purpose: Power-of-two strobe divider, one strobe every 2**sel cycles
// Assumes: Select changes are rare; a change restarts the count
// Notes: Strobe is high every cycle when sel is zero or bypass is set
`timescale 1ns/1ns
module oscsd_pow2_div #(
  parameter int unsigned SEL_W = 3
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // Control
  input wire logic bypass_i,
  input wire logic [SEL_W-1:0] sel_i,
  // Strobe out
  output logic strobe_o
);

  localparam int unsigned CNT_W = (1 << SEL_W);

  logic [CNT_W-1:0] cnt_q; // Running count
  logic [CNT_W-1:0] last_w; // Terminal count for current select
  logic [SEL_W-1:0] sel_q; // Select seen last cycle

  // Terminal count is 2**sel - 1
  assign last_w = CNT_W'((CNT_W+1)'(1) << sel_i) - CNT_W'(1);

  // Counter, restarts on select change
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= '0;
      sel_q <= '0;
    end else begin
      sel_q <= sel_i;
      if (bypass_i || sel_q != sel_i || cnt_q >= last_w) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
  end

  // Registered strobe
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      strobe_o <= 1'b0;
    end else begin
      strobe_o <= bypass_i || (cnt_q >= last_w);
    end
  end

endmodule

/* File: rtl/oscsd_top.sv */
// Purpose: Oscillator source select, switch sequencing, slowdown and postscale control
// Assumes: All inputs synchronous to sys_clk_i; strobes one cycle long
// Notes: Clock gating itself is outside; this block issues enables and selects
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ns
// Operation
// - Hardware reports active source, read only
// - Software writes requested source, same encoding
// - Requested source loads from boot configuration
// - PLL lock clears on switch, non-PLL mode
// - Lockout resets zero, software sets only
// - Clock fail set by hardware, software clears
// - Drive strength ignored with digital input
// - Interrupt clears slowdown when recover set
// - Ratio applies only while slowdown enabled
// - Fast RC postscale divides by 2**n
// - Trim register adjusts fast RC frequency
// - Unimplemented bits read as zero
module oscsd_top import oscsd_pkg::*; #(
  parameter int unsigned TRIM_W = 6,
  parameter int unsigned SWITCH_CYCLES = OSCSD_SWITCH_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // Register port
  input wire logic [OSCSD_AW-1:0] reg_addr_i,
  input wire logic [OSCSD_DW-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [OSCSD_DW-1:0] reg_rdata_o,
  // Configuration and status inputs
  input wire logic [2:0] boot_source_cfg_i,
  input wire logic secondary_input_kind_i,
  input wire logic pll_locked_i,
  input wire logic clk_fail_i,
  input wire logic lockout_hw_set_i,
  input wire logic lockout_hw_clr_i,
  input wire logic cpu_irq_i,
  // Clock control outputs
  output logic [2:0] active_source_o,
  output logic switching_o,
  output logic secondary_osc_on_o,
  output logic secondary_drive_o,
  output logic cpu_clk_en_o,
  output logic fast_rc_div_en_o,
  output logic [TRIM_W-1:0] fast_rc_trim_o,
  // Interrupt
  output logic irq_o
);

  // Elaboration checks
  if (TRIM_W < 1 || TRIM_W > OSCSD_DW) begin : g_bad_trim
    $error("TRIM_W must lie between 1 and the data width");
  end
  if (SWITCH_CYCLES < 1 || SWITCH_CYCLES > 4096) begin : g_bad_sw
    $error("SWITCH_CYCLES must lie between 1 and 4096");
  end

  localparam int unsigned SWC_W = $clog2(SWITCH_CYCLES + 1);

  oscsd_osc_ctl_t osc_q; // Oscillator control register
  oscsd_clk_div_t div_q; // Clock divide register
  logic [TRIM_W-1:0] trim_q; // Fast RC trim
  logic [OSCSD_IRQ_N-1:0] irq_stat_q; // Sticky event bits
  logic [OSCSD_IRQ_N-1:0] irq_en_q; // Event enables
  logic boot_done_q; // Boot config captured
  oscsd_sw_state_t sw_state_q; // Switch sequencer
  logic [SWC_W-1:0] sw_cnt_q; // Settle counter
  logic pll_lock_d; // Next PLL lock value
  logic [OSCSD_IRQ_N-1:0] irq_evt_w; // Event pulses this cycle
  logic irq_pll_prev_q; // Lock seen last cycle

  // Decoded write strobes
  logic wr_osc_w;
  logic wr_div_w;
  logic wr_trim_w;
  logic wr_en_w;
  logic wr_clr_w;
  assign wr_osc_w = reg_we_i && (reg_addr_i == OSCSD_OFF_OSC_CONTROL);
  assign wr_div_w = reg_we_i && (reg_addr_i == OSCSD_OFF_CLOCK_DIVIDE);
  assign wr_trim_w = reg_we_i && (reg_addr_i == OSCSD_OFF_FAST_RC_TRIM);
  assign wr_en_w = reg_we_i && (reg_addr_i == OSCSD_OFF_IRQ_ENABLE);
  assign wr_clr_w = reg_we_i && (reg_addr_i == OSCSD_OFF_IRQ_CLEAR);

  // Source uses the PLL
  function automatic logic src_has_pll(input logic [2:0] src);
    src_has_pll = (src == OSCSD_SRC_FAST_RC_PLL) || (src == OSCSD_SRC_PRIMARY_PLL);
  endfunction

  // Boot configuration capture, one cycle after reset release
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      boot_done_q <= 1'b0;
    end else begin
      boot_done_q <= 1'b1;
    end
  end

  // Switch sequencer: request, settle, commit
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sw_state_q <= OSCSD_SW_IDLE;
      sw_cnt_q <= '0;
    end else begin
      case (sw_state_q)
        OSCSD_SW_IDLE: begin
          // Start only when requested and not locked out
          if (boot_done_q && osc_q.switch_request && !osc_q.switch_lockout) begin
            sw_state_q <= OSCSD_SW_WAIT;
            sw_cnt_q <= SWC_W'(SWITCH_CYCLES - 1);
          end
        end
        OSCSD_SW_WAIT: begin
          // Count the settle cycles down while the new source settles
          if (sw_cnt_q == '0) begin
            sw_state_q <= OSCSD_SW_DONE;
          end else begin
            sw_cnt_q <= sw_cnt_q - SWC_W'(1);
          end
        end
        OSCSD_SW_DONE: begin
          sw_state_q <= OSCSD_SW_IDLE;
        end
        default: begin
          sw_state_q <= OSCSD_SW_IDLE;
        end
      endcase
    end
  end

  // PLL lock follows the input only in a settled PLL mode
  always_comb begin
    pll_lock_d = pll_locked_i && src_has_pll(osc_q.active_source_sel);
    if (sw_state_q != OSCSD_SW_IDLE) begin
      pll_lock_d = 1'b0;
    end
  end

  // Source fields and switch request
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      osc_q.active_source_sel <= OSCSD_SRC_FAST_RC;
      osc_q.requested_source_sel <= OSCSD_SRC_FAST_RC;
      osc_q.switch_request <= 1'b0;
    end else if (!boot_done_q) begin
      // Both fields start from the boot configuration
      osc_q.active_source_sel <= boot_source_cfg_i;
      osc_q.requested_source_sel <= boot_source_cfg_i;
    end else begin
      if (wr_osc_w) begin
        osc_q.requested_source_sel <= reg_wdata_i[10:8];
        osc_q.switch_request <= reg_wdata_i[0];
      end
      // Commit ends the switch and drops the request
      if (sw_state_q == OSCSD_SW_DONE) begin
        osc_q.active_source_sel <= osc_q.requested_source_sel;
        osc_q.switch_request <= 1'b0;
      end
    end
  end

  // PLL lock status, hardware only
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      osc_q.pll_lock <= 1'b0;
    end else begin
      osc_q.pll_lock <= pll_lock_d;
    end
  end

  // Lockout: software may only set, hardware sets and clears
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      osc_q.switch_lockout <= 1'b0;
    end else if (lockout_hw_set_i || (wr_osc_w && reg_wdata_i[7])) begin
      osc_q.switch_lockout <= 1'b1;
    end else if (lockout_hw_clr_i) begin
      osc_q.switch_lockout <= 1'b0;
    end
  end

  // Clock fail: hardware sets, software write of zero clears, set wins
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      osc_q.clk_fail_flag <= 1'b0;
    end else if (clk_fail_i) begin
      osc_q.clk_fail_flag <= 1'b1;
    end else if (wr_osc_w && !reg_wdata_i[3]) begin
      osc_q.clk_fail_flag <= 1'b0;
    end
  end

  // Secondary oscillator control bits
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      osc_q.secondary_drive_strength <= 1'b0;
      osc_q.secondary_osc_on <= 1'b0;
    end else if (wr_osc_w) begin
      osc_q.secondary_drive_strength <= reg_wdata_i[2];
      osc_q.secondary_osc_on <= reg_wdata_i[1];
    end
  end

  // Clock divide register with recover-on-interrupt
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_q.recover_on_irq <= 1'b0;
      div_q.slowdown_ratio <= OSCSD_RST_SLOWDOWN_RATIO;
      div_q.slowdown_enable <= 1'b0;
      div_q.fast_rc_postscale <= OSCSD_RST_POSTSCALE;
    end else begin
      if (wr_div_w) begin
        div_q.recover_on_irq <= reg_wdata_i[15];
        div_q.slowdown_ratio <= reg_wdata_i[14:12];
        div_q.slowdown_enable <= reg_wdata_i[11];
        div_q.fast_rc_postscale <= reg_wdata_i[10:8];
      end
      // Hardware clear beats a same-cycle software write
      if (div_q.recover_on_irq && cpu_irq_i) begin
        div_q.slowdown_enable <= 1'b0;
      end
    end
  end

  // Fast RC trim register
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      trim_q <= '0;
    end else if (wr_trim_w) begin
      trim_q <= reg_wdata_i[TRIM_W-1:0];
    end
  end

  // Event pulses
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_pll_prev_q <= 1'b0;
    end else begin
      irq_pll_prev_q <= osc_q.pll_lock;
    end
  end
  always_comb begin
    irq_evt_w = '0;
    irq_evt_w[OSCSD_IRQ_SWITCH_DONE] = (sw_state_q == OSCSD_SW_DONE);
    irq_evt_w[OSCSD_IRQ_CLK_FAIL] = clk_fail_i;
    irq_evt_w[OSCSD_IRQ_PLL_LOCK] = osc_q.pll_lock && !irq_pll_prev_q;
  end

  // Sticky status, write-one-to-clear, set wins
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~(wr_clr_w ? reg_wdata_i[OSCSD_IRQ_N-1:0] : '0))
                    | irq_evt_w;
    end
  end

  // Interrupt enables
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_en_q <= '0;
    end else if (wr_en_w) begin
      irq_en_q <= reg_wdata_i[OSCSD_IRQ_N-1:0];
    end
  end

  // Interrupt line
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_q & irq_en_q);
    end
  end

  // Read data, one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= '0;
    end else if (reg_re_i) begin
      case (reg_addr_i)
        OSCSD_OFF_OSC_CONTROL: begin
          // Bits 15, 11, 6 and 4 read zero
          reg_rdata_o <= {1'b0, osc_q.active_source_sel, 1'b0,
                          osc_q.requested_source_sel, osc_q.switch_lockout, 1'b0,
                          osc_q.pll_lock, 1'b0, osc_q.clk_fail_flag,
                          osc_q.secondary_drive_strength, osc_q.secondary_osc_on,
                          osc_q.switch_request};
        end
        OSCSD_OFF_CLOCK_DIVIDE: begin
          reg_rdata_o <= {div_q, 8'h00};
        end
        OSCSD_OFF_FAST_RC_TRIM: begin
          reg_rdata_o <= OSCSD_DW'(trim_q);
        end
        OSCSD_OFF_IRQ_STATUS: begin
          reg_rdata_o <= OSCSD_DW'(irq_stat_q);
        end
        OSCSD_OFF_IRQ_ENABLE: begin
          reg_rdata_o <= OSCSD_DW'(irq_en_q);
        end
        default: begin
          reg_rdata_o <= '0;
        end
      endcase
    end else begin
      reg_rdata_o <= '0;
    end
  end

  // Clock control outputs from flops
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      active_source_o <= OSCSD_SRC_FAST_RC;
      switching_o <= 1'b0;
      secondary_osc_on_o <= 1'b0;
      secondary_drive_o <= 1'b0;
      fast_rc_trim_o <= '0;
    end else begin
      active_source_o <= osc_q.active_source_sel;
      switching_o <= (sw_state_q != OSCSD_SW_IDLE);
      secondary_osc_on_o <= osc_q.secondary_osc_on;
      // High drive only for a crystal
      secondary_drive_o <= osc_q.secondary_drive_strength && secondary_input_kind_i;
      fast_rc_trim_o <= trim_q;
    end
  end

  // Postscale applies only in the two divided RC modes
  logic postscale_on_w;
  assign postscale_on_w = (osc_q.active_source_sel == OSCSD_SRC_FAST_RC_DIV) ||
                          (osc_q.active_source_sel == OSCSD_SRC_LP_FAST_RC_DIV);

  // Processor clock enable, 1:2**ratio while slowdown is on
  oscsd_pow2_div #(
    .SEL_W(3)
  ) u_slowdown_div (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .bypass_i(!div_q.slowdown_enable),
    .sel_i(div_q.slowdown_ratio),
    .strobe_o(cpu_clk_en_o)
  );

  // Fast RC postscale enable, divide by 2**n
  oscsd_pow2_div #(
    .SEL_W(3)
  ) u_postscale_div (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .bypass_i(!postscale_on_w),
    .sel_i(div_q.fast_rc_postscale),
    .strobe_o(fast_rc_div_en_o)
  );

endmodule

/* File: verif/oscsd_top_props.sv */
// Purpose: Port-level assertions for the oscillator select and slowdown block
// Assumes: Single clock domain, bound onto oscsd_top
// Notes: Helper counters track time since reset, switch length and strobe gaps
`timescale 1ns/1ns
module oscsd_top_props import oscsd_pkg::*; #(
  parameter int unsigned SWITCH_CYCLES = OSCSD_SWITCH_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // Register port
  input wire logic [OSCSD_AW-1:0] reg_addr_i,
  input wire logic reg_re_i,
  input wire logic [OSCSD_DW-1:0] reg_rdata_o,
  // Clock control
  input wire logic secondary_input_kind_i,
  input wire logic [2:0] active_source_o,
  input wire logic switching_o,
  input wire logic secondary_drive_o,
  input wire logic cpu_clk_en_o,
  input wire logic fast_rc_div_en_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [1:0] up_q; // Edges since reset, saturating
  logic [7:0] sw_len_q; // Cycles of the current switch
  logic [8:0] gap_q; // Cycles since last processor strobe
  // Settling counter after reset
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  // Length of each switching pulse
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) sw_len_q <= 8'h00;
    else sw_len_q <= switching_o ? sw_len_q + 8'h01 : 8'h00;
  end
  // Gap between processor strobes, saturating
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) gap_q <= 9'h000;
    else if (cpu_clk_en_o) gap_q <= 9'h000;
    else if (gap_q != 9'h1ff) gap_q <= gap_q + 9'h001;
  end
  // A read strobe at one address
  sequence s_rd(logic [7:0] a);
    reg_re_i && reg_addr_i == a;
  endsequence
  rd_idle_a: assert property (!$past(reg_re_i) |-> reg_rdata_o == 16'h0000)
    else $error("read data not zero outside a read");
  unmapped_zero_a: assert property (s_rd(8'h18) |=> reg_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  clear_rd_a: assert property (s_rd(OSCSD_OFF_IRQ_CLEAR) |=> reg_rdata_o == 16'h0000)
    else $error("clear register read not zero");
  div_low_a: assert property (s_rd(OSCSD_OFF_CLOCK_DIVIDE) |=> reg_rdata_o[7:0] == 8'h00)
    else $error("divide low byte not zero");
  osc_gaps_a: assert property (s_rd(OSCSD_OFF_OSC_CONTROL) |=>
    !reg_rdata_o[15] && !reg_rdata_o[11] && !reg_rdata_o[6] && !reg_rdata_o[4])
    else $error("unused control bits not zero");
  sw_len_a: assert property ($fell(switching_o) |-> sw_len_q == SWITCH_CYCLES + 1)
    else $error("switch length wrong");
  src_move_a: assert property (up_q == 2'h3 && $changed(active_source_o) |->
    $past(switching_o) || $past(switching_o, 2))
    else $error("active source moved without a switch");
  ps_bypass_a: assert property (up_q == 2'h3 && active_source_o < 3'h6 &&
    $stable(active_source_o) |-> fast_rc_div_en_o)
    else $error("postscale strobe missing outside divided modes");
  cpu_gap_a: assert property (gap_q <= 9'h12c)
    else $error("processor strobe gap too long");
  drive_gate_a: assert property (!$past(secondary_input_kind_i) |-> !secondary_drive_o)
    else $error("drive active with digital input");
endmodule
bind oscsd_top oscsd_top_props #(.SWITCH_CYCLES(SWITCH_CYCLES)) oscsd_top_props_inst (
  .sys_clk_i, .arst_n_i, .reg_addr_i, .reg_re_i, .reg_rdata_o, .secondary_input_kind_i,
  .active_source_o, .switching_o, .secondary_drive_o, .cpu_clk_en_o, .fast_rc_div_en_o
);

/* File: verif/oscsd_top_tb.sv */
// Purpose: Self-checking bench for the oscillator select and slowdown block
// Assumes: Short switch settle count; bench drives every port itself
// Notes: Random trim and postscale values come from a fixed seed
`timescale 1ns/1ns
module oscsd_top_tb import oscsd_pkg::*; ;
  localparam int unsigned SWC = 2; // Short settle count
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata, rv;
  logic we = 1'b0, re = 1'b0;
  logic kind = 1'b1, pll = 1'b1, cfail = 1'b0, lk_set = 1'b0, lk_clr = 1'b0, cirq = 1'b0;
  logic [2:0] act;
  logic swg, son, sdrv, cen, fen, irq;
  logic [5:0] trim;
  int error_cnt = 0, cmp_count = 0, cyc = 0, n, v, p;
  always #20 sys_clk = ~sys_clk;
  oscsd_top #(.TRIM_W(6), .SWITCH_CYCLES(SWC)) oscsd_top_inst (
    .sys_clk_i(sys_clk), .arst_n_i(arst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .boot_source_cfg_i(3'h2),
    .secondary_input_kind_i(kind), .pll_locked_i(pll), .clk_fail_i(cfail),
    .lockout_hw_set_i(lk_set), .lockout_hw_clr_i(lk_clr), .cpu_irq_i(cirq),
    .active_source_o(act), .switching_o(swg), .secondary_osc_on_o(son),
    .secondary_drive_o(sdrv), .cpu_clk_en_o(cen), .fast_rc_div_en_o(fen),
    .fast_rc_trim_o(trim), .irq_o(irq)
  );
  // Expected control word after a finished switch to s
  function automatic logic [15:0] exp_osc(input logic [2:0] s);
    exp_osc = {1'b0, s, 1'b0, s, 2'b00, (s == 3'h1 || s == 3'h3), 5'h00};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Compares %0d, errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge sys_clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    addr <= a;
    re <= 1'b1;
    @(posedge sys_clk);
    re <= 1'b0;
    #1 rv = rdata;
  endtask
  // Wait out a switch, bounded
  task automatic wait_idle();
    step(4);
    for (int i = 0; i < 100 && swg !== 1'b0; i++) step(1);
    step(3);
  endtask
  // Cycles between two strobes of one divider
  task automatic gap(input bit sel);
    for (int i = 0; i < 600 && (sel ? fen : cen) !== 1'b1; i++) step(1);
    step(1);
    for (n = 1; n < 600 && (sel ? fen : cen) !== 1'b1; n++) step(1);
  endtask
  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    v = $urandom(32'hc5ec);
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    step(3);
    rd(OSCSD_OFF_OSC_CONTROL);
    chk(rv, 16'h2200);
    rd(OSCSD_OFF_CLOCK_DIVIDE);
    chk(rv, 16'h3100);
    // Every source code in turn
    for (int s = 0; s < 8; s++) begin
      wr(OSCSD_OFF_OSC_CONTROL, {5'h00, 3'(s), 8'h01});
      wait_idle();
      rd(OSCSD_OFF_OSC_CONTROL);
      chk(rv, exp_osc(3'(s)));
      chk({13'h0000, act}, {13'h0000, 3'(s)});
    end
    // Masked, enabled, cleared interrupt
    chk({15'h0000, irq}, 16'h0000);
    wr(OSCSD_OFF_IRQ_ENABLE, 16'h0001);
    step(3);
    chk({15'h0000, irq}, 16'h0001);
    rd(OSCSD_OFF_IRQ_STATUS);
    chk(rv, 16'h0005);
    wr(OSCSD_OFF_IRQ_CLEAR, 16'h0007);
    step(3);
    chk({15'h0000, irq}, 16'h0000);
    // Lockout holds a pending request
    wr(OSCSD_OFF_OSC_CONTROL, 16'h0281);
    wr(OSCSD_OFF_OSC_CONTROL, 16'h0201);
    wait_idle();
    rd(OSCSD_OFF_OSC_CONTROL);
    chk(rv, 16'h7281);
    @(posedge sys_clk) lk_clr <= 1'b1;
    @(posedge sys_clk) lk_clr <= 1'b0;
    wait_idle();
    rd(OSCSD_OFF_OSC_CONTROL);
    chk(rv, 16'h2200);
    @(posedge sys_clk) lk_set <= 1'b1;
    @(posedge sys_clk) lk_set <= 1'b0;
    rd(OSCSD_OFF_OSC_CONTROL);
    chk(rv, 16'h2280);
    // Software write of zero must not clear lockout
    wr(OSCSD_OFF_OSC_CONTROL, 16'h0200);
    rd(OSCSD_OFF_OSC_CONTROL);
    chk(rv, 16'h2280);
    @(posedge sys_clk) lk_clr <= 1'b1;
    @(posedge sys_clk) lk_clr <= 1'b0;
    // Clock fail set by hardware, cleared only by writing zero
    @(posedge sys_clk) cfail <= 1'b1;
    @(posedge sys_clk) cfail <= 1'b0;
    wr(OSCSD_OFF_OSC_CONTROL, 16'h0208);
    rd(OSCSD_OFF_OSC_CONTROL);
    chk(rv, 16'h2208);
    wr(OSCSD_OFF_OSC_CONTROL, 16'h0200);
    rd(OSCSD_OFF_OSC_CONTROL);
    chk(rv, 16'h2200);
    // Software write of one must not set the flag
    wr(OSCSD_OFF_OSC_CONTROL, 16'h0208);
    rd(OSCSD_OFF_OSC_CONTROL);
    chk(rv, 16'h2200);
    // Drive strength against input kind
    @(posedge sys_clk) kind <= 1'b0;
    wr(OSCSD_OFF_OSC_CONTROL, 16'h0206);
    step(3);
    chk({14'h0000, sdrv, son}, 16'h0001);
    @(posedge sys_clk) kind <= 1'b1;
    step(3);
    chk({14'h0000, sdrv, son}, 16'h0003);
    // Recover on interrupt, on and off
    for (int k = 1; k >= 0; k--) begin
      wr(OSCSD_OFF_CLOCK_DIVIDE, {1'(k), 15'h1900});
      @(posedge sys_clk) cirq <= 1'b1;
      @(posedge sys_clk) cirq <= 1'b0;
      rd(OSCSD_OFF_CLOCK_DIVIDE);
      chk(rv, k ? 16'h9100 : 16'h1900);
    end
    // Every slowdown ratio, then slowdown off
    for (int r = 0; r < 8; r++) begin
      wr(OSCSD_OFF_CLOCK_DIVIDE, {1'b0, 3'(r), 1'b1, 3'h1, 8'h00});
      step(3);
      gap(1'b0);
      chk(16'(n), 16'(1 << r));
    end
    wr(OSCSD_OFF_CLOCK_DIVIDE, 16'h7100);
    step(3);
    gap(1'b0);
    chk(16'(n), 16'h0001);
    gap(1'b1);
    chk(16'(n), 16'h0001);
    // Postscale in both divided fast RC modes
    for (int s = 7; s >= 6; s--) begin
      wr(OSCSD_OFF_OSC_CONTROL, {5'h00, 3'(s), 8'h01});
      wait_idle();
      for (int j = 0; j < 2; j++) begin
        p = j ? 7 : $urandom_range(6);
        wr(OSCSD_OFF_CLOCK_DIVIDE, {5'h00, 3'(p), 8'h00});
        step(3);
        gap(1'b1);
        chk(16'(n), 16'(1 << p));
      end
    end
    // Random trim values
    repeat (3) begin
      v = $urandom;
      wr(OSCSD_OFF_FAST_RC_TRIM, {10'h000, v[5:0]});
      rd(OSCSD_OFF_FAST_RC_TRIM);
      chk(rv, {10'h000, v[5:0]});
      chk({10'h000, trim}, {10'h000, v[5:0]});
    end
    // Unmapped place ignores writes
    wr(8'h18, 16'hffff);
    rd(8'h18);
    chk(rv, 16'h0000);
    rd(OSCSD_OFF_IRQ_CLEAR);
    chk(rv, 16'h0000);
    wrap_up();
  end
endmodule
